// ---- i2c_seq_regs.svh ----
`ifndef I2C_SEQ_REGS_SVH
`define I2C_SEQ_REGS_SVH
// ==========================================================
// device register offsets (device register port)
`define DEV_CONTROL_OFS    2'h0
`define DEV_STATUS_ONE_OFS 2'h1
`define DEV_STATUS_TWO_OFS 2'h2
`define DEV_DATA_OFS       2'h3
// ==========================================================
// control_reg fields
`define CR_PERIPH_ON  5
`define CR_GENCALL_EN 4
`define CR_START      3
`define CR_ACK        2
`define CR_STOP       1
`define CR_IRQ_EN     0
`define CR_RESET      8'h00
// ==========================================================
// status_one fields
`define S1_EVENT       7
`define S1_HEADER_SENT 6
`define S1_TRA         5
`define S1_BYTE_DONE   3
`define S1_ADDR_MATCH  2
`define S1_MASTER      1
`define S1_START_SENT  0
// ==========================================================
// status_two fields
`define S2_NACK     4
`define S2_STOP     3
`define S2_ARB_LOST 2
`define S2_BUS_ERR  1
// ==========================================================
// host register offsets
`define H_CTRL_OFS  8'h00
`define H_ADDR1_OFS 8'h04
`define H_ADDR2_OFS 8'h08
`define H_TX_OFS    8'h0C
`define H_RX_OFS    8'h10
`define H_STAT_OFS  8'h14
`define H_SR1_OFS   8'h18
`define H_SR2_OFS   8'h1C
// ==========================================================
// host ctrl fields
`define HC_EN      0
`define HC_ACK     1
`define HC_GC      2
`define HC_GO      3
`define HC_STOP    4
`define HC_RELEASE 5
// ==========================================================
// timing and fill values
`define SETTLE_CYC 4'h4
`define NACK_FILL  8'hFF
`endif

// ---- i2c_seq_pkg.sv ----
package i2c_seq_pkg;
  // ========================================================
  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_EN2, S_REL, S_SR1, S_SR2, S_DEC, S_RDDR, S_RXW, S_PSTOP
  } seq_state_t;

  // ========================================================
  // whole state of the host
  typedef struct packed {
    seq_state_t st;
    logic       irq_s1;
    logic       irq_s2;
    logic       en;
    logic       ack;
    logic       gc;
    logic       dev_on;
    logic       go_req;
    logic       stop_req;
    logic       rel_req;
    logic       cr_dirty;
    logic       sr2_ok;
    logic       tx_valid;
    logic       rx_valid;
    logic       nack_seen;
    logic       arb_lost;
    logic [7:0] addr1;
    logic [7:0] addr2;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    logic [7:0] sr1;
    logic [7:0] sr2;
    logic [7:0] hrdata;
    logic [3:0] settle;
    logic [1:0] daddr;
    logic [7:0] dwdata;
    logic       dwr;
    logic       drd;
  } host_state_t;
endpackage : i2c_seq_pkg

// ---- i2c_event_host.sv ----
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_seq_regs.svh"

// Functional notes
// - address match event is cleared by a status one read alone
// - received byte: read status one, then read data register
// - transmitted byte: read status one, then write next byte
// - slave transmitter nack sets nack and byte done; status one read clears nack
// - after slave nack, write all-ones to data to release byte done
// - slave stop seen is cleared by reading status two
// - start sent: read status one, then write slave address
// - master address done: read status one, then rewrite control register
// - header sent: read status one, then write second address byte
// - enabling takes two control writes with the enable bit set
// - slave stop bit releases lines after byte done; software clears it
module i2c_event_host
  import i2c_seq_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // host register port
  input  wire logic [7:0] host_addr,
  input  wire logic [7:0] host_wdata,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  output var  logic [7:0] host_rdata,
  // device register port
  output var  logic [1:0] dev_addr,
  output var  logic [7:0] dev_wdata,
  output var  logic       dev_wr,
  output var  logic       dev_rd,
  input  wire logic [7:0] dev_rdata,
  input  wire logic       dev_irq
);
  import i2c_seq_pkg::*;

  host_state_t s_r;
  host_state_t s_nxt;

  // ========================================================
  // control byte built from the host settings
  function automatic logic [7:0] cr_val(input host_state_t s, input logic start,
                                        input logic stop);
    logic [7:0] v;
    v = `CR_RESET;                       // bits 7:6 stay zero
    v[`CR_PERIPH_ON]  = s.en;
    v[`CR_GENCALL_EN] = s.gc;
    v[`CR_START]      = start;
    v[`CR_ACK]        = s.ack;
    v[`CR_STOP]       = stop;
    v[`CR_IRQ_EN]     = s.en;            // one shared request
    // a disable write is all zero; ack or general call left set there is meaningless
    if (!s.en) v = `CR_RESET;
    return v;
  endfunction : cr_val

  // ========================================================
  // next state
  always_comb begin
    s_nxt        = s_r;
    s_nxt.irq_s1 = dev_irq;
    s_nxt.irq_s2 = s_r.irq_s1;
    s_nxt.dwr    = 1'b0;
    s_nxt.drd    = 1'b0;
    s_nxt.hrdata = 8'h00;
    if (s_r.settle != 4'h0) begin
      s_nxt.settle = s_r.settle - 4'h1;
    end
    // host reads; a clear here loses to a set below
    if (host_rd) begin
      if (host_addr == `H_CTRL_OFS) begin
        s_nxt.hrdata = {2'b00, s_r.rel_req, s_r.stop_req, s_r.go_req, s_r.gc,
                        s_r.ack, s_r.en};
      end else if (host_addr == `H_ADDR1_OFS) begin
        s_nxt.hrdata = s_r.addr1;
      end else if (host_addr == `H_ADDR2_OFS) begin
        s_nxt.hrdata = s_r.addr2;
      end else if (host_addr == `H_TX_OFS) begin
        s_nxt.hrdata = s_r.tx_byte;
      end else if (host_addr == `H_RX_OFS) begin
        s_nxt.hrdata   = s_r.rx_byte;
        s_nxt.rx_valid = 1'b0;
      end else if (host_addr == `H_STAT_OFS) begin
        s_nxt.hrdata = {2'b00, s_r.arb_lost, s_r.nack_seen, s_r.dev_on,
                        s_r.st != S_IDLE, s_r.rx_valid, s_r.tx_valid};
      end else if (host_addr == `H_SR1_OFS) begin
        s_nxt.hrdata = s_r.sr1;
      end else if (host_addr == `H_SR2_OFS) begin
        s_nxt.hrdata = s_r.sr2;
      end
    end
    // write one to clear the sticky error bits
    if (host_wr && host_addr == `H_STAT_OFS) begin
      if (host_wdata[4]) s_nxt.nack_seen = 1'b0;
      if (host_wdata[5]) s_nxt.arb_lost  = 1'b0;
    end
    // event sequencer
    case (s_r.st)
      S_IDLE: begin
        if (s_r.cr_dirty) begin
          s_nxt.cr_dirty = 1'b0;
          s_nxt.dwr      = 1'b1;
          s_nxt.daddr    = `DEV_CONTROL_OFS;
          s_nxt.dwdata   = cr_val(s_r, 1'b0, 1'b0); // stop bit cleared by us
          s_nxt.dev_on   = s_r.en;
          if (s_r.en && !s_r.dev_on) begin
            s_nxt.st = S_EN2;                       // first write only enables
          end
        end else if (s_r.go_req && s_r.dev_on) begin
          s_nxt.go_req = 1'b0;
          s_nxt.dwr    = 1'b1;
          s_nxt.daddr  = `DEV_CONTROL_OFS;
          s_nxt.dwdata = cr_val(s_r, 1'b1, 1'b0);
        end else if (s_r.rel_req && s_r.dev_on) begin
          s_nxt.dwr    = 1'b1;
          s_nxt.daddr  = `DEV_CONTROL_OFS;
          s_nxt.dwdata = cr_val(s_r, 1'b0, 1'b1);  // slave release
          s_nxt.st     = S_REL;
        end else if (s_r.irq_s2 && s_r.settle == 4'h0 && s_r.dev_on) begin
          // status two first: the status one read would wipe the nack flag
          // a halted device raises no request, so nothing starts here
          s_nxt.drd    = 1'b1;
          s_nxt.daddr  = `DEV_STATUS_TWO_OFS;
          s_nxt.sr2_ok = 1'b0;
          s_nxt.st     = S_SR2;
        end
      end
      S_EN2: begin
        // the first write only set the enable, so repeat it in full
        s_nxt.dwr    = 1'b1;                        // second write takes the rest
        s_nxt.daddr  = `DEV_CONTROL_OFS;
        s_nxt.dwdata = cr_val(s_r, 1'b0, 1'b0);
        s_nxt.st     = S_IDLE;
      end
      S_REL: begin
        // stop low again, or the device keeps releasing the lines
        s_nxt.dwr     = 1'b1;                       // software clears stop itself
        s_nxt.daddr   = `DEV_CONTROL_OFS;
        s_nxt.dwdata  = cr_val(s_r, 1'b0, 1'b0);
        s_nxt.rel_req = 1'b0;
        s_nxt.st      = S_IDLE;
      end
      S_SR1: begin
        s_nxt.sr1    = dev_rdata;                   // also clears addr match and nack
        s_nxt.st     = S_DEC;
      end
      S_SR2: begin
        s_nxt.sr2    = dev_rdata;                   // stop seen cleared by this read
        s_nxt.sr2_ok = 1'b1;
        if (dev_rdata[`S2_NACK])     s_nxt.nack_seen = 1'b1;
        if (dev_rdata[`S2_ARB_LOST]) s_nxt.arb_lost  = 1'b1; // device drops master
        // now status one, which opens every read-then-access clear
        s_nxt.drd   = 1'b1;
        s_nxt.daddr = `DEV_STATUS_ONE_OFS;
        s_nxt.st    = S_SR1;
      end
      S_DEC: begin
        // decide from both snapshots of this service
        if (s_r.sr1[`S1_START_SENT]) begin
          s_nxt.dwr    = 1'b1;
          s_nxt.daddr  = `DEV_DATA_OFS;
          s_nxt.dwdata = s_r.addr1;
          s_nxt.st     = S_IDLE;
          s_nxt.settle = `SETTLE_CYC;
        end else if (s_r.sr1[`S1_HEADER_SENT]) begin
          s_nxt.dwr    = 1'b1;
          s_nxt.daddr  = `DEV_DATA_OFS;
          s_nxt.dwdata = s_r.addr2;
          s_nxt.st     = S_IDLE;
          s_nxt.settle = `SETTLE_CYC;
        end else if (s_r.sr1[`S1_ADDR_MATCH]) begin
          s_nxt.st     = S_IDLE;                    // status one read was enough
          s_nxt.settle = `SETTLE_CYC;
        end else if (s_r.sr1[`S1_BYTE_DONE] && s_r.sr1[`S1_TRA]) begin
          // a slave nack shows only in the status two snapshot
          if (!s_r.sr1[`S1_MASTER] && s_r.sr2[`S2_NACK]) begin
            s_nxt.dwr    = 1'b1;
            s_nxt.daddr  = `DEV_DATA_OFS;
            s_nxt.dwdata = `NACK_FILL;
            s_nxt.st     = S_IDLE;
            s_nxt.settle = `SETTLE_CYC;
          end else if (s_r.tx_valid) begin
            s_nxt.dwr      = 1'b1;
            s_nxt.daddr    = `DEV_DATA_OFS;
            s_nxt.dwdata   = s_r.tx_byte;
            s_nxt.tx_valid = 1'b0;
            s_nxt.settle   = `SETTLE_CYC;
            s_nxt.st = (s_r.stop_req && s_r.sr1[`S1_MASTER]) ? S_PSTOP : S_IDLE;
          end
          // no byte yet: wait here, device keeps SCL low
        end else if (s_r.sr1[`S1_BYTE_DONE]) begin
          if (s_r.stop_req && s_r.sr1[`S1_MASTER]) begin
            s_nxt.dwr      = 1'b1;                  // stop before the last read
            s_nxt.daddr    = `DEV_CONTROL_OFS;
            s_nxt.dwdata   = cr_val(s_r, 1'b0, 1'b1);
            s_nxt.stop_req = 1'b0;
            s_nxt.st       = S_RDDR;
          end else if (!s_r.rx_valid) begin
            s_nxt.drd   = 1'b1;
            s_nxt.daddr = `DEV_DATA_OFS;
            s_nxt.st    = S_RXW;
          end
          // unread byte: stall, device keeps SCL low
        end else if (s_r.sr2_ok && s_r.sr1[`S1_MASTER] && s_r.sr2[4:1] == 4'h0) begin
          // master with no stop or error pending: the address has gone out
          s_nxt.dwr    = 1'b1;
          s_nxt.daddr  = `DEV_CONTROL_OFS;
          s_nxt.dwdata = cr_val(s_r, 1'b0, 1'b0);
          s_nxt.st     = S_IDLE;
          s_nxt.settle = `SETTLE_CYC;
        end else begin
          s_nxt.st     = S_IDLE;
          s_nxt.settle = `SETTLE_CYC;
        end
      end
      S_RDDR: begin
        // stop is queued; the data read now finishes the last byte
        if (!s_r.rx_valid) begin
          s_nxt.drd   = 1'b1;
          s_nxt.daddr = `DEV_DATA_OFS;
          s_nxt.st    = S_RXW;
        end
      end
      S_RXW: begin
        // data register read completes the received-byte clear
        s_nxt.rx_byte  = dev_rdata;
        s_nxt.rx_valid = 1'b1;
        s_nxt.st       = S_IDLE;
        s_nxt.settle   = `SETTLE_CYC;
      end
      S_PSTOP: begin
        // the device drops the stop bit itself once the stop is sent
        s_nxt.dwr      = 1'b1;                      // stop after last byte
        s_nxt.daddr    = `DEV_CONTROL_OFS;
        s_nxt.dwdata   = cr_val(s_r, 1'b0, 1'b1);
        s_nxt.stop_req = 1'b0;
        s_nxt.st       = S_IDLE;
      end
      default: begin
        s_nxt.st = S_IDLE;
      end
    endcase
    // host writes last so their sets win over sequencer clears
    if (host_wr) begin
      if (host_addr == `H_CTRL_OFS) begin
        s_nxt.en       = host_wdata[`HC_EN];
        s_nxt.ack      = host_wdata[`HC_ACK];
        s_nxt.gc       = host_wdata[`HC_GC];
        s_nxt.cr_dirty = 1'b1;
        if (host_wdata[`HC_GO])      s_nxt.go_req   = 1'b1;
        if (host_wdata[`HC_STOP])    s_nxt.stop_req = 1'b1;
        if (host_wdata[`HC_RELEASE]) s_nxt.rel_req  = 1'b1;
        if (!host_wdata[`HC_EN]) begin
          s_nxt.go_req   = 1'b0;                    // disable drops pending orders
          s_nxt.stop_req = 1'b0;
          s_nxt.rel_req  = 1'b0;
        end
      end else if (host_addr == `H_ADDR1_OFS) begin
        s_nxt.addr1 = host_wdata;
      end else if (host_addr == `H_ADDR2_OFS) begin
        s_nxt.addr2 = host_wdata;
      end else if (host_addr == `H_TX_OFS) begin
        s_nxt.tx_byte  = host_wdata;
        s_nxt.tx_valid = 1'b1;
      end
    end
  end

  // ========================================================
  // state register; the whole struct clears on reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ========================================================
  // outputs come straight from the state flops
  assign host_rdata = s_r.hrdata;
  assign dev_addr   = s_r.daddr;
  assign dev_wdata  = s_r.dwdata;
  assign dev_wr     = s_r.dwr;
  assign dev_rd     = s_r.drd;

endmodule : i2c_event_host
`default_nettype wire

// ---- i2c_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "i2c_seq_regs.svh"
// ==========================================================
// device model: control, status and data registers
module i2c_dev_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // register port
  input  wire logic [1:0] dev_addr,
  input  wire logic [7:0] dev_wdata,
  input  wire logic       dev_wr,
  input  wire logic       dev_rd,
  output var  logic [7:0] dev_rdata,
  output var  logic       dev_irq,
  // bench side: one-hot event kick, received byte, register view
  input  wire logic [7:0] ev,
  input  wire logic [7:0] rx_byte,
  output var  logic [7:0] cr,
  output var  logic [7:0] sr1,
  output var  logic [7:0] sr2,
  output var  logic [7:0] dr_out
);
  logic       sb, header_sent_flag, tra, byte_done_flag, addr_match_flag, msl, ev6, af, stop_seen_flag, rd1, scl_low;
  logic [7:0] dr;
  logic [7:0] rd_v;
  // any pending flag raises the event bit
  assign sr1     = {sb | header_sent_flag | byte_done_flag | addr_match_flag | ev6 | af | stop_seen_flag,
                    header_sent_flag, tra, 1'b0, byte_done_flag, addr_match_flag, msl, sb};
  assign sr2     = {3'h0, af, stop_seen_flag, 3'h0};
  assign dev_irq = cr[0] & sr1[7];
  assign scl_low = sb | header_sent_flag | byte_done_flag | addr_match_flag | ev6;
  // read data stand beside the strobe; an idle port shows the inverse
  always_comb begin
    if (dev_addr == `DEV_CONTROL_OFS) rd_v = cr;
    else if (dev_addr == `DEV_STATUS_ONE_OFS) rd_v = sr1;
    else if (dev_addr == `DEV_STATUS_TWO_OFS) rd_v = sr2;
    else rd_v = dr;
    dev_rdata = dev_rd ? rd_v : ~rd_v;
  end
  // bench events first, accesses after, so a clear wins a tie
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      {sb, header_sent_flag, tra, byte_done_flag, addr_match_flag, msl, ev6, af, stop_seen_flag, rd1} <= '0;
      cr        <= 8'h00;
      dr        <= 8'h00;
      dr_out    <= 8'h00;
    end else begin
      if (ev[0]) {sb, msl, cr[3]} <= 3'b110;
      if (ev[1]) header_sent_flag <= 1'b1;
      if (ev[2]) addr_match_flag <= 1'b1;
      if (ev[3]) {byte_done_flag, tra} <= 2'b11;
      if (ev[4]) {byte_done_flag, dr} <= {1'b1, rx_byte};
      if (ev[5]) {af, byte_done_flag, tra} <= 3'b111;
      if (ev[6]) {stop_seen_flag, msl} <= 2'b10;
      if (ev[6] && msl) cr[`CR_STOP] <= 1'b0; // master stop sent
      if (ev[7]) ev6 <= 1'b1;
      if (dev_rd) begin
        if (dev_addr == `DEV_STATUS_ONE_OFS) {rd1, addr_match_flag, af} <= 3'b100;
        if (dev_addr == `DEV_STATUS_TWO_OFS) {stop_seen_flag, af} <= 2'b00;
        if (dev_addr == `DEV_DATA_OFS && rd1) {rd1, byte_done_flag, tra} <= 3'b000;
      end
      if (dev_wr && dev_addr == `DEV_DATA_OFS) begin
        dr_out <= dev_wdata;
        rd1    <= 1'b0;
        if (rd1) {sb, header_sent_flag, byte_done_flag, tra} <= 4'h0;
      end
      if (dev_wr && dev_addr == `DEV_CONTROL_OFS) begin
        if (rd1) ev6 <= 1'b0;
        if (!dev_wdata[5]) begin
          cr <= cr & 8'h02;
          {sb, header_sent_flag, tra, byte_done_flag, addr_match_flag, msl, ev6, af, stop_seen_flag} <= '0;
        end else if (!cr[5]) cr <= 8'h20;
        else cr <= dev_wdata & 8'h3F;
      end
    end
  end
endmodule : i2c_dev_model
`default_nettype wire

// ---- i2c_event_host_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "i2c_seq_regs.svh"
// ==========================================================
// checker on the host's ports
module i2c_event_host_checker (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // host register port
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic       host_wr,
  input wire logic       host_rd,
  input wire logic [7:0] host_rdata,
  // device register port
  input wire logic [1:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic       dev_wr,
  input wire logic       dev_rd,
  input wire logic [7:0] dev_rdata,
  input wire logic       dev_irq
);
  logic on_r, sr1_r, cw, dw;
  assign cw = dev_wr && dev_addr == `DEV_CONTROL_OFS;
  assign dw = dev_wr && dev_addr == `DEV_DATA_OFS;
  // last written enable; a status-one read still owed its data access
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      on_r  <= 1'b0;
      sr1_r <= 1'b0;
    end else begin
      if (cw) on_r <= dev_wdata[5];
      if (dev_rd && dev_addr == `DEV_STATUS_ONE_OFS) sr1_r <= 1'b1;
      else if ((dev_wr || dev_rd) && dev_addr == `DEV_DATA_OFS) sr1_r <= 1'b0;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_ctrl_top_zero: assert property (cw |-> dev_wdata[7:6] == 2'b00)
    else $error("control bits 7:6 written high");
  a_enable_twice: assert property (cw && dev_wdata[5] && !on_r |=> cw && dev_wdata[5])
    else $error("enable not written twice");
  a_irq_en_pe: assert property (cw |-> dev_wdata[0] == dev_wdata[5])
    else $error("irq enable differs from enable");
  a_disable_zero: assert property (cw && !dev_wdata[5] |-> dev_wdata == 8'h00)
    else $error("disable write not all zero");
  a_start_on: assert property (cw && dev_wdata[3] |-> dev_wdata[5])
    else $error("start requested while disabled");
  a_data_wr_order: assert property (dw |-> sr1_r)
    else $error("data write without status one read");
  a_data_rd_order: assert property (dev_rd && dev_addr == `DEV_DATA_OFS |-> sr1_r)
    else $error("data read without status one read");
  a_irq_served: assert property ($rose(dev_irq) |-> ##[1:16] dev_rd && dev_addr == 2'h1)
    else $error("interrupt not serviced");
endmodule : i2c_event_host_checker
bind i2c_event_host i2c_event_host_checker i2c_event_host_checker_i (.clk_sys, .reset_n,
  .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata, .dev_addr, .dev_wdata,
  .dev_wr, .dev_rd, .dev_rdata, .dev_irq);
`default_nettype wire

// ---- i2c_event_host_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "i2c_seq_regs.svh"
module i2c_event_host_test;
  logic       clk_sys, reset_n, host_wr, host_rd, dev_wr, dev_rd, dev_irq;
  logic [7:0] host_addr, host_wdata, host_rdata, dev_wdata, dev_rdata;
  logic [7:0] ev, rx_byte, cr, sr1, sr2, dr_out;
  logic [1:0] dev_addr;
  int         mismatches, n_tests;
  i2c_event_host i2c_event_host_i (.clk_sys, .reset_n, .host_addr, .host_wdata, .host_wr,
    .host_rd, .host_rdata, .dev_addr, .dev_wdata, .dev_wr, .dev_rd, .dev_rdata, .dev_irq);
  i2c_dev_model i2c_dev_model_i (.clk_sys, .reset_n, .dev_addr, .dev_wdata, .dev_wr, .dev_rd,
    .dev_rdata, .dev_irq, .ev, .rx_byte, .cr, .sr1, .sr2, .dr_out);
  // ==========================================================
  // clock, 25 ns
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // host port cycles and comparisons
  task automatic hw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    host_addr  <= a;
    host_wdata <= d;
    host_wr    <= 1'b1;
    @(posedge clk_sys);
    host_wr <= 1'b0;
  endtask : hw
  task automatic hr(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    host_addr <= a;
    host_rd   <= 1'b1;
    @(posedge clk_sys);
    host_rd <= 1'b0;
    @(posedge clk_sys);
    d = host_rdata;
  endtask : hr
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    hr(a, d);
    chk(nm, e, d);
  endtask : rchk
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // polls busy and the request line; a hang counts as a mismatch
  task automatic settle;
    logic [7:0] s;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 60; i++) begin
      hr(`H_STAT_OFS, s);
      if (s[2] === 1'b0 && dev_irq === 1'b0) return;
    end
    mismatches++;
    close_out();
  endtask : settle
  task automatic fire(input int k);
    @(posedge clk_sys);
    ev <= 8'h01 << k;
    @(posedge clk_sys);
    ev <= 8'h00;
    settle();
  endtask : fire
  // ==========================================================
  // main sequence
  initial begin
    reset_n    = 1'b0;
    host_wr    = 1'b0;
    host_rd    = 1'b0;
    host_addr  = 8'h00;
    host_wdata = 8'h00;
    ev         = 8'h00;
    rx_byte    = 8'hC3;
    mismatches = 0;
    n_tests    = 0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    rchk(`H_CTRL_OFS, 8'h00, "ctrl reset");
    rchk(8'h20, 8'h00, "unmapped read");
    chk("device control reset", 8'h00, cr);
    // enable with acknowledge: second write carries the other bits
    hw(`H_CTRL_OFS, 8'h03);
    settle();
    chk("control enabled", 8'h25, cr);
    rchk(`H_STAT_OFS, 8'h08, "device on");
    // master: start, 10-bit header, address done
    hw(`H_ADDR1_OFS, 8'hF4);
    hw(`H_ADDR2_OFS, 8'h71);
    hw(`H_CTRL_OFS, 8'h0B);
    settle();
    chk("start requested", 8'h2D, cr);
    fire(0);
    chk("address byte", 8'hF4, dr_out);
    chk("start cleared", 8'h02, sr1);
    rchk(`H_SR1_OFS, 8'h83, "start snapshot");
    fire(1);
    chk("second address", 8'h71, dr_out);
    fire(7);
    chk("address done", 8'h02, sr1);
    // master transmit, then receive
    hw(`H_TX_OFS, 8'h5A);
    fire(3);
    chk("sent byte", 8'h5A, dr_out);
    chk("tx cleared", 8'h02, sr1);
    fire(4);
    rchk(`H_RX_OFS, 8'hC3, "received byte");
    chk("rx cleared", 8'h02, sr1);
    // last received byte: stop goes out before the data read
    rx_byte <= 8'h96;
    hw(`H_CTRL_OFS, 8'h13);
    fire(4);
    chk("stop requested", 8'h27, cr);
    rchk(`H_RX_OFS, 8'h96, "last byte");
    // stop drops to slave; address match, slave send, refused byte
    fire(6);
    chk("stop cleared", 8'h00, sr2);
    chk("slave mode", 8'h00, sr1);
    chk("stop bit dropped", 8'h25, cr);
    rchk(`H_SR2_OFS, 8'h08, "stop snapshot");
    fire(2);
    chk("match cleared", 8'h00, sr1);
    hw(`H_TX_OFS, 8'h3C);
    fire(3);
    chk("slave byte", 8'h3C, dr_out);
    fire(5);
    chk("nack fill", 8'hFF, dr_out);
    chk("nack sr1", 8'h00, sr1);
    rchk(`H_STAT_OFS, 8'h18, "nack seen");
    hw(`H_STAT_OFS, 8'h10);
    rchk(`H_STAT_OFS, 8'h08, "nack acked");
    // slave release: stop bit raised, then lowered by the host
    hw(`H_CTRL_OFS, 8'h23);
    settle();
    chk("release done", 8'h25, cr);
    rchk(`H_CTRL_OFS, 8'h03, "release cleared");
    // disable with ack and general call still set, then enable again
    hw(`H_CTRL_OFS, 8'h06);
    settle();
    chk("control off", 8'h00, cr);
    rchk(`H_STAT_OFS, 8'h00, "device off");
    hw(`H_CTRL_OFS, 8'h05);
    settle();
    chk("general call on", 8'h31, cr);
    rchk(`H_CTRL_OFS, 8'h05, "ctrl readback");
    close_out();
  end
endmodule : i2c_event_host_test
`default_nettype wire
